// ### logic/udc_counter.sv
/*
 * Four-bit up/down counter with separate up and down count clocks,
 * parallel load, master clear and cascade carry/borrow outputs.
 * Assumes all counter pins come from outside the ref_clk domain and
 * change slowly against the 50 MHz sampling clock.
 */
// Operation
// - Four-bit count changes only on a count clock rise, load or clear.
// - Up clock rise with down clock High increments the count by one.
// - Down clock rise with up clock High decrements the count by one.
// - Carry rests High; at count 15 it copies the up clock level.
// - Borrow rests High; at count zero it copies the down clock level.
// - Carry and borrow feed the next stage's up and down clocks.
// - Low load copies the preset inputs into the count, ignoring clocks.
// - Clear forces zero, overrides both clocks and beats the load.
// - A clock held Low through clear or load counts on its next rise.
`timescale 1ns/1ps
`default_nettype none
module udc_counter (
    input wire logic ref_clk, // 50 MHz sampling clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic up_count_clock, // Count-up clock pin
    input wire logic down_count_clock, // Count-down clock pin
    input wire logic preset_load_n, // Parallel load, active low
    input wire logic clear_all, // Master clear, active high
    input wire logic [udc_pkg::CNT_W-1:0] preset_value_in, // Parallel data
    output logic [udc_pkg::CNT_W-1:0] count_value_out, // Current count
    output logic carry_out_n, // Terminal count up, active low
    output logic borrow_out_n // Terminal count down, active low
);
    udc_pkg::udc_pins_t pins_in;
    udc_pkg::udc_pins_t meta_q, meta_d;
    udc_pkg::udc_pins_t sync_q, sync_d;
    logic up_prev_q, up_prev_d;
    logic down_prev_q, down_prev_d;
    logic [udc_pkg::CNT_W-1:0] count_q, count_d;
    logic carry_n_q, carry_n_d;
    logic borrow_n_q, borrow_n_d;
    logic up_rise, down_rise;

    assign pins_in = '{
        up_clk: up_count_clock,
        down_clk: down_count_clock,
        load_n: preset_load_n,
        clear: clear_all,
        preset: preset_value_in
    };

    // Edge detectors keep tracking during clear and load
    assign up_rise = sync_q.up_clk & ~up_prev_q;
    assign down_rise = sync_q.down_clk & ~down_prev_q;

    // Two synchroniser stages, then one stage of history for the edge detectors
    always_comb begin
        meta_d = pins_in;
        sync_d = meta_q;
        up_prev_d = sync_q.up_clk;
        down_prev_d = sync_q.down_clk;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= udc_pkg::PINS_RST;
            sync_q <= udc_pkg::PINS_RST;
            up_prev_q <= udc_pkg::PINS_RST.up_clk;
            down_prev_q <= udc_pkg::PINS_RST.down_clk;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            up_prev_q <= up_prev_d;
            down_prev_q <= down_prev_d;
        end
    end

    // Clear beats load, load beats counting
    always_comb begin
        count_d = count_q;
        if (sync_q.clear) begin
            count_d = udc_pkg::CNT_ZERO;
        end else if (!sync_q.load_n) begin
            count_d = sync_q.preset;
        end else if (up_rise && sync_q.down_clk && !down_rise) begin
            count_d = count_q + udc_pkg::CNT_STEP;
        end else if (down_rise && sync_q.up_clk && !up_rise) begin
            count_d = count_q - udc_pkg::CNT_STEP;
        end
        // A rise while the other clock is Low is dropped
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= udc_pkg::CNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    // Terminal outputs move in the same cycle as the count they belong to
    always_comb begin
        carry_n_d = !((count_d == udc_pkg::CNT_MAX) && !sync_q.up_clk);
        borrow_n_d = !((count_d == udc_pkg::CNT_ZERO) && !sync_q.down_clk);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            carry_n_q <= udc_pkg::TC_IDLE;
            borrow_n_q <= udc_pkg::TC_IDLE;
        end else begin
            carry_n_q <= carry_n_d;
            borrow_n_q <= borrow_n_d;
        end
    end

    assign count_value_out = count_q;
    assign carry_out_n = carry_n_q;
    assign borrow_out_n = borrow_n_q;

    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    chk_clear_zero: assert property (
        sync_q.clear |=> count_q == udc_pkg::CNT_ZERO)
        else $error("clear did not force zero");
    chk_clear_over_load: assert property (
        sync_q.clear && !sync_q.load_n |=> count_q != $past(sync_q.preset) || count_q == 4'h0)
        else $error("load won over clear");
    chk_load_copy: assert property (
        !sync_q.clear && !sync_q.load_n |=> count_q == $past(sync_q.preset))
        else $error("load did not copy preset");
    chk_up_step: assert property (
        !sync_q.clear && sync_q.load_n && up_rise && sync_q.down_clk && !down_rise
        |=> count_q == $past(count_q) + 4'h1)
        else $error("up count step wrong");
    chk_down_step: assert property (
        !sync_q.clear && sync_q.load_n && down_rise && sync_q.up_clk && !up_rise
        |=> count_q == $past(count_q) - 4'h1)
        else $error("down count step wrong");
    chk_count_hold: assert property (
        !sync_q.clear && sync_q.load_n && !up_rise && !down_rise |=> $stable(count_q))
        else $error("count moved without cause");
    chk_carry_copy: assert property (
        1'b1 |=> carry_out_n == !(count_q == 4'hf && !$past(sync_q.up_clk)))
        else $error("carry does not follow up clock at 15");
    chk_borrow_copy: assert property (
        1'b1 |=> borrow_out_n == !(count_q == 4'h0 && !$past(sync_q.down_clk)))
        else $error("borrow does not follow down clock at zero");
    chk_wrap_up: assert property (
        count_q == 4'hf && up_rise && sync_q.down_clk && !down_rise
        && !sync_q.clear && sync_q.load_n |=> count_q == 4'h0)
        else $error("count did not wrap to zero");

    chk_wrap_down: assert property (
        count_q == 4'h0 && down_rise && sync_q.up_clk && !up_rise
        && !sync_q.clear && sync_q.load_n |=> count_q == 4'hf)
        else $error("count did not wrap to fifteen");

    chk_up_low_drop: assert property (
        !sync_q.clear && sync_q.load_n && up_rise && !sync_q.down_clk |=> $stable(count_q))
        else $error("up rise counted with down clock Low");

    chk_down_low_drop: assert property (
        !sync_q.clear && sync_q.load_n && down_rise && !sync_q.up_clk |=> $stable(count_q))
        else $error("down rise counted with up clock Low");

    chk_both_rise_drop: assert property (
        !sync_q.clear && sync_q.load_n && up_rise && down_rise |=> $stable(count_q))
        else $error("simultaneous rises moved the count");

    chk_load_over_clock: assert property (
        !sync_q.clear && !sync_q.load_n && (up_rise || down_rise)
        |=> count_q == $past(sync_q.preset))
        else $error("clock rise disturbed a load");

    chk_edge_track: assert property (
        1'b1 |=> up_prev_q == $past(sync_q.up_clk) && down_prev_q == $past(sync_q.down_clk))
        else $error("edge history lost during clear or load");

    chk_carry_rest: assert property (
        count_q != 4'hf |-> carry_out_n)
        else $error("carry Low away from fifteen");

    chk_borrow_rest: assert property (
        count_q != 4'h0 |-> borrow_out_n)
        else $error("borrow Low away from zero");

    chk_carry_low_max: assert property (
        count_q == 4'hf && !sync_q.up_clk && !sync_q.clear && sync_q.load_n |=> !carry_out_n)
        else $error("carry stayed High at fifteen with up clock Low");

    chk_borrow_low_zero: assert property (
        count_q == 4'h0 && !sync_q.down_clk && !sync_q.clear && sync_q.load_n
        |=> !borrow_out_n)
        else $error("borrow stayed High at zero with down clock Low");

    chk_carry_clock_high: assert property (
        sync_q.up_clk |=> carry_out_n)
        else $error("carry Low while up clock High");

    chk_borrow_clock_high: assert property (
        sync_q.down_clk |=> borrow_out_n)
        else $error("borrow Low while down clock High");

    chk_borrow_in_clear: assert property (
        sync_q.clear && !sync_q.down_clk |=> !borrow_out_n)
        else $error("borrow did not follow down clock during clear");

    chk_carry_in_clear: assert property (
        sync_q.clear |=> carry_out_n)
        else $error("carry Low during clear");

    chk_load_zero_borrow: assert property (
        !sync_q.clear && !sync_q.load_n && sync_q.preset == 4'h0 && !sync_q.down_clk
        |=> !borrow_out_n)
        else $error("borrow did not follow down clock on a load of zero");

    // Main scenarios

    cov_up_wrap: cover property (count_q == 4'hf ##1 count_q == 4'h0 && !sync_q.clear);
    cov_down_wrap: cover property (count_q == 4'h0 ##1 count_q == 4'hf && sync_q.load_n);
    cov_carry_pulse: cover property (!carry_out_n ##1 carry_out_n);
    cov_borrow_in_clear: cover property (sync_q.clear && !borrow_out_n);
    cov_count_after_clear: cover property ($fell(sync_q.clear) ##[1:8] count_q == 4'hf);
endmodule // udc_counter
`default_nettype wire

// ### logic/udc_pkg.sv
/*
 * Shared constants and types for the dual-clock up/down counter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package udc_pkg;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic TC_IDLE = 1'b1;

    // Pin levels as they arrive, and after each synchroniser stage
    typedef struct packed {
        logic up_clk;
        logic down_clk;
        logic load_n;
        logic clear;
        logic [CNT_W-1:0] preset;
    } udc_pins_t;

    localparam udc_pins_t PINS_RST = '{
        up_clk: 1'b1, down_clk: 1'b1, load_n: 1'b1, clear: 1'b0, preset: 4'h0
    };
endpackage : udc_pkg

// ### verification/dual_clock_updown_counter_tb.sv
/* Self-checking bench for the up/down counter.
   Assumes the three-edge pin latency of the design. */
`timescale 1ns/1ps
`default_nettype none
module dual_clock_updown_counter_tb;
    logic ref_clk = 1'b0, rst_b = 1'b0, ld_n = 1'b1, clr = 1'b0;
    logic [3:0] pv = 4'h0, cnt;
    logic up, dn, c_n, b_n;
    logic [3:0] hi;
    wire logic [5:0] o = {cnt, c_n, b_n};
    int num_errors = 0, num_checks = 0;
    udc_clk_drv drv (.ref_clk(ref_clk), .rst_b(rst_b), .carry_out_n(c_n),
        .borrow_out_n(b_n), .up_count_clock(up), .down_count_clock(dn), .next_count(hi));
    udc_counter i_udc_counter (.ref_clk(ref_clk), .rst_b(rst_b), .up_count_clock(up),
        .down_count_clock(dn), .preset_load_n(ld_n), .clear_all(clr),
        .preset_value_in(pv), .count_value_out(cnt), .carry_out_n(c_n), .borrow_out_n(b_n));
    initial forever #10 ref_clk = ~ref_clk;
    task automatic chk(input logic [5:0] s, input logic [5:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic pin(input logic l, input logic c, input logic [3:0] v);
        @(negedge ref_clk);
        ld_n = l;
        clr = c;
        pv = v;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic t_up();
        pin(1'b0, 1'b0, 4'he);
        chk(o, {4'he, 2'b11});
        pin(1'b1, 1'b0, 4'he);
        drv.lvl(1'b0, 1'b1);
        drv.lvl(1'b1, 1'b1);
        chk(o, {4'hf, 2'b11});
        drv.lvl(1'b0, 1'b1);
        chk(o, {4'hf, 2'b01});
        drv.lvl(1'b1, 1'b1);
        chk(o, {4'h0, 2'b11});
        chk({2'b00, hi}, {2'b00, 4'h1});
        $display("up test done");
    endtask
    task automatic t_dn();
        drv.lvl(1'b1, 1'b0);
        chk(o, {4'h0, 2'b10});
        drv.lvl(1'b1, 1'b1);
        chk(o, {4'hf, 2'b11});
        chk({2'b00, hi}, {2'b00, 4'h0});
        $display("down test done");
    endtask
    task automatic t_clr();
        pin(1'b0, 1'b0, 4'h5);
        drv.lvl(1'b1, 1'b0);
        chk(o, {4'h5, 2'b11});
        pin(1'b0, 1'b1, 4'h5);
        chk(o, {4'h0, 2'b10});
        pin(1'b1, 1'b0, 4'h5);
        drv.lvl(1'b1, 1'b1);
        chk(o, {4'hf, 2'b11});
        chk({2'b00, hi}, {2'b00, 4'hf});
        $display("clear test done");
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100us;
        num_errors++;
        final_report();
    end
    initial begin
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        chk(o, {4'h0, 2'b11});
        t_up();
        t_dn();
        t_clr();
        final_report();
    end
endmodule // dual_clock_updown_counter_tb
`default_nettype wire

// ### verification/udc_clk_drv.sv
/* Count clock driver and next cascaded stage on the far side of the counter.
   Assumes one bench process calls lvl at a time. */
`timescale 1ns/1ps
`default_nettype none
module udc_clk_drv (
    input wire logic ref_clk, // Sampling clock
    input wire logic rst_b, // Bench reset, active low
    input wire logic carry_out_n, // Lower stage carry, next stage up clock
    input wire logic borrow_out_n, // Lower stage borrow, next stage down clock
    output logic up_count_clock, // Up clock pin
    output logic down_count_clock, // Down clock pin
    output logic [3:0] next_count // Count of the next higher stage
);
    // Next higher stage counts on one terminal output's rise while the other is High
    int ups = 0;
    int downs = 0;
    always @(posedge carry_out_n) if (rst_b && borrow_out_n) ups++;
    always @(posedge borrow_out_n) if (rst_b && carry_out_n) downs++;
    assign next_count = 4'(ups - downs);
    initial begin
        up_count_clock = 1'b1;
        down_count_clock = 1'b1;
    end
    // Idle clock kept High; never both Low at once
    task automatic lvl(input logic u, input logic d);
        @(negedge ref_clk);
        up_count_clock = u;
        down_count_clock = d | ~u;
        repeat (4) @(negedge ref_clk);
    endtask
endmodule // udc_clk_drv
`default_nettype wire
